// *** design/wkint_pkg.sv ***
// Package: register map, field positions, reset values and carrier types
package wkint_pkg;

  // ==========================================
  // Register bus geometry
  localparam int ADDR_W = 4;   // Word index width
  localparam int DATA_W = 8;   // Register width

  // ==========================================
  // Register offsets
  localparam logic [3:0] OFF_EDGE_SEL = 4'h0;  // wakeup_edge_select
  localparam logic [3:0] OFF_EN_ONE   = 4'h1;  // interrupt_enable_one
  localparam logic [3:0] OFF_EN_TWO   = 4'h2;  // interrupt_enable_two
  localparam logic [3:0] OFF_PEND_ONE = 4'h3;  // Pin request flags
  localparam logic [3:0] OFF_PEND_TWO = 4'h4;  // Peripheral request flags
  localparam logic [3:0] OFF_PEND_WK  = 4'h5;  // Wakeup request flags
  localparam logic [3:0] OFF_STATUS   = 4'h6;  // Sticky event status
  localparam logic [3:0] OFF_MASK     = 4'h7;  // Event interrupt mask

  // ==========================================
  // Field positions, enable register one
  localparam int B1_ALARM = 7;  // clock_alarm_int_enable
  localparam int B1_RSV   = 6;  // Reads as one
  localparam int B1_WAKE  = 5;  // wake_group_int_enable
  localparam int B1_EXT4  = 4;  // ext_int_4_enable
  localparam int B1_EXT3  = 3;  // ext_int_3_enable
  localparam int B1_EDGE  = 2;  // edge_counter_pin_int_enable
  localparam int B1_EXT1  = 1;  // ext_int_1_enable
  localparam int B1_EXT0  = 0;  // ext_int_0_enable

  // ==========================================
  // Field positions, enable register two
  localparam int B2_DT    = 7;  // direct_transition_int_enable
  localparam int B2_CONV  = 6;  // converter_done_int_enable
  localparam int B2_SPARE = 5;  // Plain storage bit
  localparam int B2_RSV4  = 4;  // Reads as one
  localparam int B2_TFH   = 3;  // timer_f_high_int_enable
  localparam int B2_TFL   = 2;  // timer_f_low_int_enable
  localparam int B2_RSV1  = 1;  // Reads as one
  localparam int B2_EVC   = 0;  // event_counter_int_enable

  // ==========================================
  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_EDGE_SEL = 8'h00;
  localparam logic [7:0] RST_EN_ONE   = 8'h40;
  localparam logic [7:0] RST_EN_TWO   = 8'h12;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] FIX_EN_ONE   = 8'h40;  // Bits forced to one on read
  localparam logic [7:0] FIX_EN_TWO   = 8'h12;
  localparam logic [7:0] IMP_PEND_ONE = 8'h1f;  // Writable flag bits
  localparam logic [7:0] FIX_PEND_ONE = 8'he0;
  localparam logic [7:0] IMP_PEND_TWO = 8'hcd;
  localparam logic [7:0] FIX_PEND_TWO = 8'h10;
  localparam logic [7:0] IMP_STATUS   = 8'h7f;

  // ==========================================
  // Status event bit positions
  localparam int S_WAKE = 0;
  localparam int S_EXT  = 1;
  localparam int S_EDGE = 2;
  localparam int S_DT   = 3;
  localparam int S_CONV = 4;
  localparam int S_TMRF = 5;
  localparam int S_EVC  = 6;

  // ==========================================
  // Peripheral request events, one-cycle pulses
  typedef struct packed {
    logic ext4;       // ext_int_pin_4 edge seen
    logic ext3;
    logic edgeCnt;    // edge_counter_int_pin edge seen
    logic ext1;
    logic ext0;
    logic directTr;
    logic convDone;
    logic tmrFHigh;
    logic tmrFLow;
    logic evCnt;
  } wkint_src_t;

  // Requests forwarded to the CPU acceptance logic
  typedef struct packed {
    logic       clockAlarm;
    logic [7:0] wake;
    logic       ext4;
    logic       ext3;
    logic       edgeCnt;
    logic       ext1;
    logic       ext0;
    logic       directTr;
    logic       convDone;
    logic       tmrFHigh;
    logic       tmrFLow;
    logic       evCnt;
  } wkint_req_t;

endpackage : wkint_pkg

// *** design/wkint_edge_det.sv ***
// Wakeup pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module wkint_edge_det (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // Pins and edge choice
  input  wire logic [7:0] wakePin,
  input  wire logic [7:0] edgeSel,
  // Detected edges
  output logic      [7:0] edgeSeen
);
  import wkint_pkg::*;

  logic [7:0] syncA;  // First stage, read only by syncB
  logic [7:0] syncB;  // Second stage
  logic [7:0] prevB;  // Previous settled level

  // ==========================================
  // Two-stage synchroniser plus history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= RST_ZERO;
      syncB <= RST_ZERO;
      prevB <= RST_ZERO;
    end else if (ce) begin
      syncA <= wakePin;
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  // Select chooses rising (1) or falling (0) per pin
  always_comb begin
    edgeSeen = (edgeSel & syncB & ~prevB) | (~edgeSel & ~syncB & prevB);
  end

endmodule : wkint_edge_det

// *** design/wkint_ctrl.sv ***
// Wakeup edge select and interrupt enable block with request flags
`timescale 1ns/1ps
module wkint_ctrl (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  // Register port
  input  wire logic [3:0]             addr,
  input  wire logic [7:0]             wrData,
  input  wire logic                   wrEn,
  input  wire logic                   rdEn,
  output logic      [7:0]             rdData,
  // Request sources
  input  wire logic [7:0]             wakePin,
  input  wire logic [7:0]             wakePinIsInt,
  input  wire wkint_pkg::wkint_src_t  srcEvent,
  input  wire logic                   clockAlarmReq,
  // Toward CPU and system
  output wkint_pkg::wkint_req_t       cpuReq,
  output logic                        irqOut
);
  import wkint_pkg::*;

  // ==========================================
  // Registers
  logic [7:0] edgeSel_reg;   // wakeup_edge_select
  logic [7:0] enOne_reg;     // interrupt_enable_one storage
  logic [7:0] enTwo_reg;     // interrupt_enable_two storage
  logic [7:0] pendOne_reg;   // Pin request flags
  logic [7:0] pendTwo_reg;   // Peripheral request flags
  logic [7:0] pendWk_reg;    // Wakeup request flags
  logic [7:0] status_reg;    // Sticky events
  logic [7:0] mask_reg;      // Event mask
  logic [7:0] rdData_reg;    // Read answer
  wkint_req_t req_reg;       // Registered requests
  logic       irq_reg;       // Registered interrupt

  // ==========================================
  // Decoded strobes and event vectors
  logic [7:0] wakeEdge;      // Edges from the detector
  logic [7:0] setOne;        // Flag sets, register one
  logic [7:0] setTwo;        // Flag sets, register two
  logic [7:0] setWk;         // Flag sets, wake
  logic [7:0] evt;           // Status events
  wkint_req_t reqNext;       // Gated requests

  // Write strobe for one offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  // Flag update: write-zero clear, set wins over clear
  function automatic logic [7:0] flagNext(input logic [7:0] cur, input logic wr,
                                          input logic [7:0] wd, input logic [7:0] set,
                                          input logic [7:0] imp);
    flagNext = (((wr ? (cur & wd) : cur) | set) & imp);
  endfunction : flagNext

  // ==========================================
  // Wakeup pin edge detection
  wkint_edge_det u_edge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .wakePin  (wakePin),
    .edgeSel  (edgeSel_reg),
    .edgeSeen (wakeEdge)
  );

  // Set vectors; only pins in interrupt mode raise flags
  always_comb begin
    setWk  = wakeEdge & wakePinIsInt;
    setOne = {3'h0, srcEvent.ext4, srcEvent.ext3, srcEvent.edgeCnt,
              srcEvent.ext1, srcEvent.ext0};
    setTwo = {srcEvent.directTr, srcEvent.convDone, 2'h0,
              srcEvent.tmrFHigh, srcEvent.tmrFLow, 1'h0, srcEvent.evCnt};
    evt         = RST_ZERO;
    evt[S_WAKE] = |setWk;
    evt[S_EXT]  = srcEvent.ext4 | srcEvent.ext3 | srcEvent.ext1 | srcEvent.ext0;
    evt[S_EDGE] = srcEvent.edgeCnt;
    evt[S_DT]   = srcEvent.directTr;
    evt[S_CONV] = srcEvent.convDone;
    evt[S_TMRF] = srcEvent.tmrFHigh | srcEvent.tmrFLow;
    evt[S_EVC]  = srcEvent.evCnt;
  end

  // ==========================================
  // Edge select register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      edgeSel_reg <= RST_EDGE_SEL;
    end else if (ce && wrEn && hit(addr, OFF_EDGE_SEL)) begin
      edgeSel_reg <= wrData;
    end
  end

  // ==========================================
  // Enable registers; fixed bits never stored as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enOne_reg <= RST_EN_ONE;
      enTwo_reg <= RST_EN_TWO;
    end else if (ce && wrEn) begin
      if (hit(addr, OFF_EN_ONE)) begin
        enOne_reg <= wrData | FIX_EN_ONE;
      end
      if (hit(addr, OFF_EN_TWO)) begin
        enTwo_reg <= wrData | FIX_EN_TWO;
      end
    end
  end

  // ==========================================
  // Request flags; a same-cycle edge survives a clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendOne_reg <= RST_ZERO;
      pendTwo_reg <= RST_ZERO;
      pendWk_reg  <= RST_ZERO;
    end else if (ce) begin
      pendOne_reg <= flagNext(pendOne_reg, wrEn && hit(addr, OFF_PEND_ONE),
                              wrData, setOne, IMP_PEND_ONE);
      pendTwo_reg <= flagNext(pendTwo_reg, wrEn && hit(addr, OFF_PEND_TWO),
                              wrData, setTwo, IMP_PEND_TWO);
      pendWk_reg  <= flagNext(pendWk_reg, wrEn && hit(addr, OFF_PEND_WK),
                              wrData, setWk, 8'hff);
    end
  end

  // ==========================================
  // Event status (write one clears) and mask
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= RST_ZERO;
      mask_reg   <= RST_ZERO;
    end else if (ce) begin
      status_reg <= ((wrEn && hit(addr, OFF_STATUS)) ? (status_reg & ~wrData)
                                                     : status_reg) | evt;
      if (wrEn && hit(addr, OFF_MASK)) begin
        mask_reg <= wrData & IMP_STATUS;
      end
    end
  end

  // ==========================================
  // Request gating: flag (clock alarm: request level) and enable both required
  always_comb begin
    reqNext            = '0;
    reqNext.clockAlarm = clockAlarmReq & enOne_reg[B1_ALARM];
    reqNext.wake       = pendWk_reg & {8{enOne_reg[B1_WAKE]}};
    reqNext.ext4       = pendOne_reg[4] & enOne_reg[B1_EXT4];
    reqNext.ext3       = pendOne_reg[3] & enOne_reg[B1_EXT3];
    reqNext.edgeCnt    = pendOne_reg[2] & enOne_reg[B1_EDGE];
    reqNext.ext1       = pendOne_reg[1] & enOne_reg[B1_EXT1];
    reqNext.ext0       = pendOne_reg[0] & enOne_reg[B1_EXT0];
    reqNext.directTr   = pendTwo_reg[7] & enTwo_reg[B2_DT];
    reqNext.convDone   = pendTwo_reg[6] & enTwo_reg[B2_CONV];
    reqNext.tmrFHigh   = pendTwo_reg[3] & enTwo_reg[B2_TFH];
    reqNext.tmrFLow    = pendTwo_reg[2] & enTwo_reg[B2_TFL];
    reqNext.evCnt      = pendTwo_reg[0] & enTwo_reg[B2_EVC];
  end

  // Outputs come from flops, one cycle behind the flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      req_reg <= reqNext;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ==========================================
  // Read port; data stands one cycle, else zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= RST_ZERO;
    end else if (ce) begin
      if (!rdEn) begin
        rdData_reg <= RST_ZERO;
      end else begin
        unique case (addr)
          OFF_EDGE_SEL: rdData_reg <= edgeSel_reg;
          OFF_EN_ONE:   rdData_reg <= enOne_reg | FIX_EN_ONE;
          OFF_EN_TWO:   rdData_reg <= enTwo_reg | FIX_EN_TWO;
          OFF_PEND_ONE: rdData_reg <= pendOne_reg | FIX_PEND_ONE;
          OFF_PEND_TWO: rdData_reg <= pendTwo_reg | FIX_PEND_TWO;
          OFF_PEND_WK:  rdData_reg <= pendWk_reg;
          OFF_STATUS:   rdData_reg <= status_reg;
          OFF_MASK:     rdData_reg <= mask_reg;
          default:      rdData_reg <= RST_ZERO;  // Unmapped reads zero
        endcase
      end
    end
  end

  assign rdData = rdData_reg;
  assign cpuReq = req_reg;
  assign irqOut = irq_reg;

  // ==========================================
  // Checks
  sequence s_rd_en_one;
    ce && rdEn && addr == OFF_EN_ONE;
  endsequence

  sequence s_rd_en_two;
    ce && rdEn && addr == OFF_EN_TWO;
  endsequence

  property p_fix_one;
    @(posedge clk) disable iff (sys_rst) s_rd_en_one |=> rdData[B1_RSV];
  endproperty
  a_fix_one: assert property (p_fix_one) else $error("enable one bit 6 read 0");

  property p_fix_two;
    @(posedge clk) disable iff (sys_rst)
      s_rd_en_two |=> rdData[B2_RSV4] && rdData[B2_RSV1];
  endproperty
  a_fix_two: assert property (p_fix_two) else $error("enable two fixed bit read 0");

  property p_alarm;
    @(posedge clk) disable iff (sys_rst)
      ce && !enOne_reg[B1_ALARM] |=> !cpuReq.clockAlarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm forwarded while off");

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      ce && !enOne_reg[B1_WAKE] |=> cpuReq.wake == 8'h00;
  endproperty
  a_wake: assert property (p_wake) else $error("wake forwarded while off");

  property p_ext4;
    @(posedge clk) disable iff (sys_rst)
      ce && pendOne_reg[4] && enOne_reg[B1_EXT4] |=> cpuReq.ext4;
  endproperty
  a_ext4: assert property (p_ext4) else $error("ext4 request missing");

  property p_edge;
    @(posedge clk) disable iff (sys_rst)
      ce && !enOne_reg[B1_EDGE] |=> !cpuReq.edgeCnt;
  endproperty
  a_edge: assert property (p_edge) else $error("edge counter forwarded while off");

  property p_dt;
    @(posedge clk) disable iff (sys_rst)
      ce && !enTwo_reg[B2_DT] |=> !cpuReq.directTr;
  endproperty
  a_dt: assert property (p_dt) else $error("direct transition forwarded while off");

  property p_conv;
    @(posedge clk) disable iff (sys_rst)
      ce && !enTwo_reg[B2_CONV] |=> !cpuReq.convDone;
  endproperty
  a_conv: assert property (p_conv) else $error("converter forwarded while off");

  property p_tfh;
    @(posedge clk) disable iff (sys_rst)
      ce && !enTwo_reg[B2_TFH] |=> !cpuReq.tmrFHigh;
  endproperty
  a_tfh: assert property (p_tfh) else $error("timer high forwarded while off");

  property p_evc;
    @(posedge clk) disable iff (sys_rst)
      ce && !enTwo_reg[B2_EVC] |=> !cpuReq.evCnt;
  endproperty
  a_evc: assert property (p_evc) else $error("event counter forwarded while off");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst) ce && srcEvent.ext0 |=> pendOne_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("ext0 flag lost");

  // A write of zero must really clear a wake flag when no edge competes
  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      ce && wrEn && addr == OFF_PEND_WK && !wrData[0] && !setWk[0] |=> !pendWk_reg[0];
  endproperty
  a_clear: assert property (p_clear) else $error("wake flag not cleared");

  property p_tfl;
    @(posedge clk) disable iff (sys_rst)
      ce && !enTwo_reg[B2_TFL] |=> !cpuReq.tmrFLow;
  endproperty
  a_tfl: assert property (p_tfl) else $error("timer low forwarded while off");

  property p_ext0;
    @(posedge clk) disable iff (sys_rst)
      ce && !enOne_reg[B1_EXT0] |=> !cpuReq.ext0;
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext0 forwarded while off");

  // Spare bit keeps exactly what software wrote
  sequence s_wr_en_two;
    ce && wrEn && addr == OFF_EN_TWO;
  endsequence

  property p_spare;
    @(posedge clk) disable iff (sys_rst)
      s_wr_en_two |=> enTwo_reg[B2_SPARE] == $past(wrData[B2_SPARE]);
  endproperty
  a_spare: assert property (p_spare) else $error("enable two spare bit not stored");

endmodule : wkint_ctrl

// *** dv/wkint_src_model.sv ***
// Request source model: peripheral event pulses, wake pins, clock alarm level
`timescale 1ns/1ps
module wkint_src_model (
  // Clock
  input  wire logic            clk,
  // Toward the block
  output logic      [7:0]      wakePin,
  output wkint_pkg::wkint_src_t srcEvent,
  output logic                 clockAlarmReq
);
  import wkint_pkg::*;

  // ==========================================
  // Idle levels
  initial begin
    wakePin       = 8'hff;  // Wake pins rest high
    srcEvent      = '0;     // No event pending
    clockAlarmReq = 1'b0;   // Alarm quiet
  end

  // ==========================================
  // Drivers, all launched just after a rising edge
  // One-cycle pulse, so a single edge sets the flag exactly once
  task automatic pulse(input int i);
    @(posedge clk);
    srcEvent[i] <= 1'b1;
    @(posedge clk);
    srcEvent    <= '0;
  endtask : pulse

  // Level change on one wake pin
  task automatic setPin(input int n, input logic v);
    @(posedge clk);
    wakePin[n] <= v;
  endtask : setPin

  // Alarm request is a level, held until changed
  task automatic setAlarm(input logic v);
    @(posedge clk);
    clockAlarmReq <= v;
  endtask : setAlarm
endmodule : wkint_src_model

// *** dv/tb_wkint_ctrl.sv ***
// Self-checking testbench for the wakeup edge select and interrupt enable block
`timescale 1ns/1ps
module tb_wkint_ctrl;
  import wkint_pkg::*;

  // ==========================================
  // Signals
  logic                  clk          = 1'b0;   // 125 MHz
  logic                  sys_rst      = 1'b1;   // Held high at start
  logic                  ce           = 1'b1;   // Running, except low for one write strobe
  logic [3:0]            addr         = 4'h0;
  logic [7:0]            wrData       = 8'h00;
  logic                  wrEn         = 1'b0;
  logic                  rdEn         = 1'b0;
  logic [7:0]            rdData;
  logic [7:0]            wakePin;
  logic [7:0]            wakePinIsInt = 8'hff;  // All pins as interrupt inputs
  wkint_src_t            srcEvent;
  logic                  clockAlarmReq;
  wkint_req_t            cpuReq;
  logic                  irqOut;
  int                    fails        = 0;
  int                    compares     = 0;
  // Flag and enable positions, indexed like the low cpuReq bits
  localparam int posTwo[5] = '{B2_EVC, B2_TFL, B2_TFH, B2_CONV, B2_DT};
  localparam int posOne[5] = '{B1_EXT0, B1_EXT1, B1_EDGE, B1_EXT3, B1_EXT4};

  always #4 clk = ~clk;

  // ==========================================
  // Design and far-side model
  wkint_ctrl u_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .wakePin(wakePin),
    .wakePinIsInt(wakePinIsInt), .srcEvent(srcEvent),
    .clockAlarmReq(clockAlarmReq), .cpuReq(cpuReq), .irqOut(irqOut)
  );
  wkint_src_model u_src (
    .clk(clk), .wakePin(wakePin), .srcEvent(srcEvent), .clockAlarmReq(clockAlarmReq)
  );

  // ==========================================
  // Bus and compare tasks
  task automatic chkRd(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkRd

  // Request and interrupt outputs, zero-extended to one width
  task automatic chkOut(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkOut

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chkRd(rdData, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // One pass over all wake pins: each pin falls then rises
  task automatic wakePass(input logic [7:0] sel, input logic [7:0] en);
    logic [7:0] exp;
    wr(OFF_EDGE_SEL, sel);
    wr(OFF_EN_ONE, en);
    idle(5);
    wr(OFF_PEND_WK, 8'h00);  // Select change may leave a stray flag
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 2; k++) begin
        u_src.setPin(n, k[0]);
        idle(5);
        exp = (sel[n] == k[0]) ? (8'h01 << n) : 8'h00;
        rd(OFF_PEND_WK, exp);
        chkOut(cpuReq.wake, exp & {8{en[B1_WAKE]}});
        wr(OFF_PEND_WK, 8'h00);
      end
    end
  endtask : wakePass

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Watchdog, well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // ==========================================
  // Test sequence
  initial begin : main
    logic       two;
    logic [7:0] bitv;
    logic [3:0] enA;
    logic [3:0] flA;
    logic [7:0] fix;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, reserved bits, unmapped index
    rd(OFF_EDGE_SEL, 8'h00);
    rd(OFF_EN_ONE, 8'h40);
    rd(OFF_EN_TWO, 8'h12);
    rd(4'h8, 8'h00);
    chkOut(cpuReq, 19'h0);
    wr(OFF_EN_ONE, 8'hff);
    rd(OFF_EN_ONE, 8'hff);
    idle(1);
    chkRd(rdData, 8'h00);     // Read data stands one cycle only
    wr(OFF_EN_ONE, 8'h00);
    rd(OFF_EN_ONE, 8'h40);
    wr(OFF_EN_TWO, 8'h20);
    rd(OFF_EN_TWO, 8'h32);
    wr(OFF_EN_TWO, 8'h00);
    rd(OFF_EN_TWO, 8'h12);
    wr(OFF_EDGE_SEL, 8'ha5);
    rd(OFF_EDGE_SEL, 8'ha5);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    // Clock enable low: a write strobe is ignored
    @(posedge clk);
    ce <= 1'b0;
    wr(OFF_EDGE_SEL, 8'h3c);
    ce <= 1'b1;
    rd(OFF_EDGE_SEL, 8'ha5);
    // Reset in mid-run returns the edge selects to falling
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_EDGE_SEL, 8'h00);
    $display("test registers done");
    // Each source: flag without enable, then gated through, then cleared
    for (int i = 0; i < 10; i++) begin
      two  = (i < 5);
      bitv = 8'h01 << (two ? posTwo[i] : posOne[i - 5]);
      enA  = two ? OFF_EN_TWO : OFF_EN_ONE;
      flA  = two ? OFF_PEND_TWO : OFF_PEND_ONE;
      fix  = two ? FIX_PEND_TWO : FIX_PEND_ONE;
      u_src.pulse(i);
      idle(2);
      chkOut(cpuReq, 19'h0);
      rd(flA, fix | bitv);
      wr(enA, bitv);
      idle(2);
      chkOut(cpuReq, 19'h1 << i);
      wr(flA, ~bitv);
      idle(2);
      chkOut(cpuReq, 19'h0);
      rd(flA, fix);
      wr(enA, 8'h00);
    end
    // Event in the same cycle as a write-zero clear keeps the flag
    fork
      u_src.pulse(5);
      wr(OFF_PEND_ONE, 8'h00);
    join
    rd(OFF_PEND_ONE, 8'he1);
    wr(OFF_PEND_ONE, 8'h00);
    $display("test source gating done");
    // Status and level interrupt
    rd(OFF_STATUS, 8'h7e);
    wr(OFF_MASK, 8'h82);
    rd(OFF_MASK, 8'h02);
    idle(2);
    chkOut(irqOut, 19'h1);
    wr(OFF_STATUS, 8'h02);
    idle(2);
    chkOut(irqOut, 19'h0);
    rd(OFF_STATUS, 8'h7c);
    $display("test interrupt done");
    // Clock alarm request gated by its enable only
    u_src.setAlarm(1'b1);
    idle(2);
    chkOut(cpuReq, 19'h0);
    wr(OFF_EN_ONE, 8'h80);
    idle(2);
    chkOut(cpuReq, 19'h1 << 18);
    wr(OFF_EN_ONE, 8'h00);
    idle(2);
    chkOut(cpuReq, 19'h0);
    u_src.setAlarm(1'b0);
    $display("test clock alarm done");
    // Wake pins: falling with group gate off, rising with it on
    wakePass(8'h00, 8'h00);
    wakePass(8'hff, 8'h20);
    // Pin not configured as interrupt input is ignored
    u_src.setPin(0, 1'b0);
    idle(5);
    wr(OFF_PEND_WK, 8'h00);
    wakePinIsInt <= 8'hfe;
    u_src.setPin(0, 1'b1);
    idle(5);
    rd(OFF_PEND_WK, 8'h00);
    $display("test wake pins done");
    end_of_test();
  end
endmodule : tb_wkint_ctrl
